// *** inc/psrc_pkg.sv ***
// package: offsets, field layouts, reset values and bus types for the peripheral soft reset block
// Overview of operation
// - writes to group1 register are masked by the second capability mask
// - writes to group2 register are masked by the fourth capability mask
// - group1 register at offset 0x044, read/write, clears to zero on reset
// - group2 register at offset 0x048, read/write, clears to zero on reset
// - group1 bit 14 resets two-wire unit 1, bit 12 two-wire unit 0
// - group1 bit 5 resets sync serial unit 1, bit 4 sync serial unit 0
// - group1 bits 2,1,0 reset async serial units 2,1,0
// - group2 bit 13 holds the micro-DMA unit in reset
// - group2 bits 4 down to 0 reset ports E, D, C, B, A
// - a module held in reset loses its state and registers
// - bits never clear themselves; software writes zero to release
// - unused bit positions are read-only zero; software writes back read value
package psrc_pkg;
   localparam logic [11:0] PSRC_OFS_GROUP1   = 12'h044;
   localparam logic [11:0] PSRC_OFS_GROUP2   = 12'h048;
   localparam logic [31:0] PSRC_RST_GROUP1   = 32'h00000000;
   localparam logic [31:0] PSRC_RST_GROUP2   = 32'h00000000;
   // implemented bits of each register
   localparam logic [31:0] PSRC_IMPL_GROUP1  = 32'h00005037;
   localparam logic [31:0] PSRC_IMPL_GROUP2  = 32'h0000201F;
   // field positions, group1
   localparam int PSRC_BIT_TW1  = 14;
   localparam int PSRC_BIT_TW0  = 12;
   localparam int PSRC_BIT_SS1  = 5;
   localparam int PSRC_BIT_SS0  = 4;
   localparam int PSRC_BIT_AS2  = 2;
   localparam int PSRC_BIT_AS1  = 1;
   localparam int PSRC_BIT_AS0  = 0;
   // field positions, group2
   localparam int PSRC_BIT_DMA  = 13;
   localparam int PSRC_BIT_PE   = 4;
   localparam int PSRC_BIT_PD   = 3;
   localparam int PSRC_BIT_PC   = 2;
   localparam int PSRC_BIT_PB   = 1;
   localparam int PSRC_BIT_PA   = 0;
   localparam logic [1:0] PSRC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] PSRC_RESP_SLVERR = 2'h2;

   // axi4-lite request channels from the master
   typedef struct packed {
      logic [11:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [11:0] araddr;
      logic        arvalid;
      logic        rready;
   } psrc_axi_req_t;

   // axi4-lite answer channels to the master
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } psrc_axi_rsp_t;

   // per-module reset lines
   typedef struct packed {
      logic twowire_unit1_reset;
      logic twowire_unit0_reset;
      logic sync_serial_unit1_reset;
      logic sync_serial_unit0_reset;
      logic async_serial_unit2_reset;
      logic async_serial_unit1_reset;
      logic async_serial_unit0_reset;
      logic micro_dma_reset;
      logic port_e_reset;
      logic port_d_reset;
      logic port_c_reset;
      logic port_b_reset;
      logic port_a_reset;
   } psrc_resets_t;
endpackage

// *** logic/psrc_reg.sv ***
// one masked software reset control register
`timescale 1ns/10ps
module psrc_reg #(
   parameter logic [31:0] IMPL  = 32'h00000000,
   parameter logic [31:0] RSTV  = 32'h00000000
) (
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_b_in,
   // write port
   input  wire logic        wr_en_in,
   input  wire logic [31:0] wr_data_in,
   input  wire logic [3:0]  wr_strb_in,
   input  wire logic [31:0] cap_mask_in,
   // stored value
   output logic [31:0]      value_out
);
   logic [31:0] lane_mask;
   logic [31:0] wr_mask;

   // byte lanes, capability mask and implemented bits form the write mask
   always_comb begin
      lane_mask = {{8{wr_strb_in[3]}}, {8{wr_strb_in[2]}},
                   {8{wr_strb_in[1]}}, {8{wr_strb_in[0]}}};
      wr_mask   = lane_mask & cap_mask_in & IMPL;
   end

   // bits hold until software writes zero
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         value_out <= RSTV;
      end else if (wr_en_in) begin
         value_out <= (value_out & ~wr_mask) | (wr_data_in & wr_mask);
      end
   end
endmodule // psrc_reg

// *** logic/psrc_top.sv ***
// peripheral soft reset control: axi4-lite slave with two masked reset registers
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module psrc_top (
   // clock and reset
   input  wire logic               core_clk_in,
   input  wire logic               rst_b_in,
   // register bus
   input  wire psrc_pkg::psrc_axi_req_t axi_req_in,
   output psrc_pkg::psrc_axi_rsp_t      axi_rsp_out,
   // capability masks from the capability registers
   input  wire logic [31:0]        capability_mask_second_in,
   input  wire logic [31:0]        capability_mask_fourth_in,
   // module reset lines
   output psrc_pkg::psrc_resets_t       resets_out
);
   import psrc_pkg::*;

   logic        aw_held;
   logic [11:0] aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_fire;
   logic        wr_g1;
   logic        wr_g2;
   logic [31:0] group1;
   logic [31:0] group2;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic        aw_ready;
   logic        w_ready;
   logic        b_valid;
   logic [1:0]  b_resp;
   logic        ar_ready;
   logic        r_valid;
   logic [31:0] r_data;
   logic [1:0]  r_resp;

   // write address capture, taken when not already held and no response pending
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end else if (axi_req_in.awvalid && axi_rsp_out.awready) begin
         aw_held <= 1'b1;
         aw_addr <= axi_req_in.awaddr;
      end
   end

   // write data capture
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end else if (axi_req_in.wvalid && axi_rsp_out.wready) begin
         w_held <= 1'b1;
         w_data <= axi_req_in.wdata;
         w_strb <= axi_req_in.wstrb;
      end
   end

   // write decode once both halves are held
   always_comb begin
      wr_fire = aw_held && w_held && !axi_rsp_out.bvalid;
      wr_g1   = wr_fire && (aw_addr[11:2] == PSRC_OFS_GROUP1[11:2]);
      wr_g2   = wr_fire && (aw_addr[11:2] == PSRC_OFS_GROUP2[11:2]);
   end

   // ready flags and write response
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         aw_ready <= 1'b0;
         w_ready  <= 1'b0;
         b_valid  <= 1'b0;
         b_resp   <= PSRC_RESP_OKAY;
      end else begin
         aw_ready <= !aw_held && !(axi_req_in.awvalid && aw_ready)
                     && !b_valid && !wr_fire;
         w_ready  <= !w_held && !(axi_req_in.wvalid && w_ready)
                     && !b_valid && !wr_fire;
         if (wr_fire) begin
            b_valid <= 1'b1;
            b_resp  <= (wr_g1 || wr_g2) ? PSRC_RESP_OKAY : PSRC_RESP_SLVERR;
         end else if (axi_req_in.bready) begin
            b_valid <= 1'b0;
         end
      end
   end

   // first register, masked by the second capability mask
   psrc_reg #(
      .IMPL (PSRC_IMPL_GROUP1),
      .RSTV (PSRC_RST_GROUP1)
   ) u_group1 (
      .core_clk_in (core_clk_in),
      .rst_b_in    (rst_b_in),
      .wr_en_in    (wr_g1),
      .wr_data_in  (w_data),
      .wr_strb_in  (w_strb),
      .cap_mask_in (capability_mask_second_in),
      .value_out   (group1)
   );

   // second register, masked by the fourth capability mask
   psrc_reg #(
      .IMPL (PSRC_IMPL_GROUP2),
      .RSTV (PSRC_RST_GROUP2)
   ) u_group2 (
      .core_clk_in (core_clk_in),
      .rst_b_in    (rst_b_in),
      .wr_en_in    (wr_g2),
      .wr_data_in  (w_data),
      .wr_strb_in  (w_strb),
      .cap_mask_in (capability_mask_fourth_in),
      .value_out   (group2)
   );

   // read data select; unused positions read zero
   always_comb begin
      next_rdata = 32'h00000000;
      next_rresp = PSRC_RESP_OKAY;
      if (axi_req_in.araddr[11:2] == PSRC_OFS_GROUP1[11:2]) begin
         next_rdata = group1 & PSRC_IMPL_GROUP1;
      end else if (axi_req_in.araddr[11:2] == PSRC_OFS_GROUP2[11:2]) begin
         next_rdata = group2 & PSRC_IMPL_GROUP2;
      end else begin
         next_rresp = PSRC_RESP_SLVERR;
      end
   end

   // read channel: arready high while idle, answer one cycle after acceptance
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ar_ready <= 1'b0;
         r_valid  <= 1'b0;
         r_data   <= 32'h00000000;
         r_resp   <= PSRC_RESP_OKAY;
      end else begin
         if (axi_req_in.arvalid && ar_ready) begin
            ar_ready <= 1'b0;
            r_valid  <= 1'b1;
            r_data   <= next_rdata;
            r_resp   <= next_rresp;
         end else if (r_valid) begin
            if (axi_req_in.rready) begin
               r_valid <= 1'b0;
            end
         end else begin
            ar_ready <= 1'b1;
         end
      end
   end

   // answer channels gathered into one struct; one process drives it, each field a flop
   always_comb begin
      axi_rsp_out.awready = aw_ready;
      axi_rsp_out.wready  = w_ready;
      axi_rsp_out.bresp   = b_resp;
      axi_rsp_out.bvalid  = b_valid;
      axi_rsp_out.arready = ar_ready;
      axi_rsp_out.rdata   = r_data;
      axi_rsp_out.rresp   = r_resp;
      axi_rsp_out.rvalid  = r_valid;
   end

   // reset lines registered from the control bits; each module is cleared while high
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         resets_out <= '0;
      end else begin
         resets_out.twowire_unit1_reset      <= group1[PSRC_BIT_TW1];
         resets_out.twowire_unit0_reset      <= group1[PSRC_BIT_TW0];
         resets_out.sync_serial_unit1_reset  <= group1[PSRC_BIT_SS1];
         resets_out.sync_serial_unit0_reset  <= group1[PSRC_BIT_SS0];
         resets_out.async_serial_unit2_reset <= group1[PSRC_BIT_AS2];
         resets_out.async_serial_unit1_reset <= group1[PSRC_BIT_AS1];
         resets_out.async_serial_unit0_reset <= group1[PSRC_BIT_AS0];
         resets_out.micro_dma_reset          <= group2[PSRC_BIT_DMA];
         resets_out.port_e_reset             <= group2[PSRC_BIT_PE];
         resets_out.port_d_reset             <= group2[PSRC_BIT_PD];
         resets_out.port_c_reset             <= group2[PSRC_BIT_PC];
         resets_out.port_b_reset             <= group2[PSRC_BIT_PB];
         resets_out.port_a_reset             <= group2[PSRC_BIT_PA];
      end
   end

   // a masked-off bit never becomes one
   property p_mask_g1;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr_g1 && !capability_mask_second_in[PSRC_BIT_TW1] && !group1[PSRC_BIT_TW1])
         |=> !group1[PSRC_BIT_TW1];
   endproperty
   a_mask_g1: assert property (p_mask_g1) else $error("masked group1 bit set");

   property p_mask_g2;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr_g2 && !capability_mask_fourth_in[PSRC_BIT_DMA] && !group2[PSRC_BIT_DMA])
         |=> !group2[PSRC_BIT_DMA];
   endproperty
   a_mask_g2: assert property (p_mask_g2) else $error("masked group2 bit set");

   property p_g1_write;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr_g1 && (&w_strb[1:0]) && capability_mask_second_in[PSRC_BIT_TW0])
         |=> group1[PSRC_BIT_TW0] == $past(w_data[PSRC_BIT_TW0]);
   endproperty
   a_g1_write: assert property (p_g1_write) else $error("group1 write lost");

   property p_g2_write;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr_g2 && w_strb[0] && capability_mask_fourth_in[PSRC_BIT_PA])
         |=> group2[PSRC_BIT_PA] == $past(w_data[PSRC_BIT_PA]);
   endproperty
   a_g2_write: assert property (p_g2_write) else $error("group2 write lost");

   property p_hold;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      !wr_g1 |=> group1 == $past(group1);
   endproperty
   a_hold: assert property (p_hold) else $error("group1 changed without write");

   property p_reserved;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      ((group1 & ~PSRC_IMPL_GROUP1) == 32'h00000000)
         && ((group2 & ~PSRC_IMPL_GROUP2) == 32'h00000000);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_tw_out;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      $rose(group1[PSRC_BIT_TW1]) |-> ##1 resets_out.twowire_unit1_reset [*2];
   endproperty
   a_tw_out: assert property (p_tw_out) else $error("two-wire reset late");

   property p_ss_out;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      ##1 resets_out.sync_serial_unit0_reset == $past(group1[PSRC_BIT_SS0]);
   endproperty
   a_ss_out: assert property (p_ss_out) else $error("sync serial reset wrong");

   property p_as_out;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      $fell(group1[PSRC_BIT_AS2]) |=> !resets_out.async_serial_unit2_reset;
   endproperty
   a_as_out: assert property (p_as_out) else $error("async serial reset stuck");

   property p_dma_out;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      group2[PSRC_BIT_DMA] |=> resets_out.micro_dma_reset;
   endproperty
   a_dma_out: assert property (p_dma_out) else $error("dma reset missing");

   property p_port_out;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      group2[PSRC_BIT_PE] |=> resets_out.port_e_reset;
   endproperty
   a_port_out: assert property (p_port_out) else $error("port e reset missing");

   // a group2 bit holds until software writes it
   property p_hold_g2;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      !wr_g2 |=> group2 == $past(group2);
   endproperty
   a_hold_g2: assert property (p_hold_g2) else $error("group2 changed without write");

   // reading group1 returns its implemented bits with an okay answer
   property p_read_g1;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (axi_req_in.arvalid && axi_rsp_out.arready
         && (axi_req_in.araddr[11:2] == PSRC_OFS_GROUP1[11:2]))
         |=> (axi_rsp_out.rdata == ($past(group1) & PSRC_IMPL_GROUP1))
            && (axi_rsp_out.rresp == PSRC_RESP_OKAY);
   endproperty
   a_read_g1: assert property (p_read_g1) else $error("group1 read wrong");

   // reading group2 returns its implemented bits with an okay answer
   property p_read_g2;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (axi_req_in.arvalid && axi_rsp_out.arready
         && (axi_req_in.araddr[11:2] == PSRC_OFS_GROUP2[11:2]))
         |=> (axi_rsp_out.rdata == ($past(group2) & PSRC_IMPL_GROUP2))
            && (axi_rsp_out.rresp == PSRC_RESP_OKAY);
   endproperty
   a_read_g2: assert property (p_read_g2) else $error("group2 read wrong");

   // a read outside both registers answers zero with a slave error
   property p_read_bad;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (axi_req_in.arvalid && axi_rsp_out.arready
         && (axi_req_in.araddr[11:2] != PSRC_OFS_GROUP1[11:2])
         && (axi_req_in.araddr[11:2] != PSRC_OFS_GROUP2[11:2]))
         |=> (axi_rsp_out.rdata == 32'h00000000)
            && (axi_rsp_out.rresp == PSRC_RESP_SLVERR);
   endproperty
   a_read_bad: assert property (p_read_bad) else $error("unmapped read not refused");

   // a write outside both registers answers with a slave error
   property p_write_bad;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr_fire && (aw_addr[11:2] != PSRC_OFS_GROUP1[11:2])
         && (aw_addr[11:2] != PSRC_OFS_GROUP2[11:2]))
         |=> axi_rsp_out.bvalid && (axi_rsp_out.bresp == PSRC_RESP_SLVERR);
   endproperty
   a_write_bad: assert property (p_write_bad) else $error("unmapped write not refused");

   // port a line follows its bit one cycle later
   property p_pa_out;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      ##1 (resets_out.port_a_reset == $past(group2[PSRC_BIT_PA]));
   endproperty
   a_pa_out: assert property (p_pa_out) else $error("port a reset wrong");

   // two-wire unit 0 line follows its bit one cycle later
   property p_tw0_out;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      ##1 (resets_out.twowire_unit0_reset == $past(group1[PSRC_BIT_TW0]));
   endproperty
   a_tw0_out: assert property (p_tw0_out) else $error("two-wire 0 reset wrong");
endmodule // psrc_top

// *** test/psrc_unit_model.sv ***
// behavioural model of the peripheral units fed by the reset lines
`timescale 1ns/10ps
module psrc_unit_model (
   // clock and reset
   input  wire logic                   core_clk_in,
   input  wire logic                   rst_b_in,
   // reset lines from the block
   input  wire psrc_pkg::psrc_resets_t resets_in,
   // per unit: state sits at its reset value
   output logic [12:0]                 fresh_out
);
   import psrc_pkg::*;
   logic [2:0] age [13];
   // each unit ages while free and drops all state while its line is high
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int k = 0; k < 13; k++) age[k] <= 3'h0;
      end else begin
         for (int k = 0; k < 13; k++) begin
            if (resets_in[k]) age[k] <= 3'h0;
            else if (age[k] != 3'h7) age[k] <= age[k] + 3'h1;
         end
      end
   end
   // flag units whose state is cleared
   always_comb begin
      for (int k = 0; k < 13; k++) fresh_out[k] = (age[k] == 3'h0);
   end
endmodule // psrc_unit_model

// *** test/tb_top.sv ***
// self-checking testbench for the peripheral soft reset block
`timescale 1ns/10ps
module tb_top;
   import psrc_pkg::*;
   logic          core_clk_in;
   logic          rst_b_in;
   psrc_axi_req_t req;
   psrc_axi_rsp_t rsp;
   logic [31:0]   cap2;
   logic [31:0]   cap4;
   psrc_resets_t  lines;
   logic [12:0]   fresh;
   logic [1:0]    wq[$];
   logic [33:0]   rq[$];
   logic [31:0]   shadow [2];
   logic [31:0]   rnd;
   psrc_resets_t  lq[$];
   psrc_resets_t  l_exp;
   logic          b_done = 1'b0;
   logic          l_done = 1'b0;
   int            miscompares = 0;
   int            comparisons = 0;
   int            seed = 32'hc9761e51;

   psrc_top u_psrc_top (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .axi_req_in(req),
      .axi_rsp_out(rsp), .capability_mask_second_in(cap2),
      .capability_mask_fourth_in(cap4), .resets_out(lines));
   psrc_unit_model u_psrc_unit_model (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
      .resets_in(lines), .fresh_out(fresh));

   // free-running clock
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end

   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
      chk("bresp", {32'h00000000, e}, {32'h00000000, g});
   endtask

   task automatic chk_read(input logic [33:0] e, input logic [33:0] g);
      chk("read", e, g);
   endtask

   task automatic chk_lines(input psrc_resets_t e, input psrc_resets_t g);
      chk("resets", {21'h000000, e}, {21'h000000, g});
   endtask

   task automatic chk_units(input psrc_resets_t e, input logic [12:0] g);
      chk("units", {21'h000000, e}, {21'h000000, g});
   endtask

   // notes left without an answer count as a mismatch
   task automatic test_done();
      if (wq.size() + rq.size() + lq.size() != 0) miscompares++;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // expected reset lines from the shadow registers, msb first
   function automatic psrc_resets_t exp_lines();
      return {shadow[0][14], shadow[0][12], shadow[0][5:4], shadow[0][2:0],
              shadow[1][13], shadow[1][4:0]};
   endfunction

   // one write; notes the response and the reset lines it must leave behind
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      logic [31:0] m;
      @(posedge core_clk_in);
      i = (a == PSRC_OFS_GROUP1) ? 0 : (a == PSRC_OFS_GROUP2) ? 1 : 2;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      m = m & ((i == 0) ? (PSRC_IMPL_GROUP1 & cap2) : (PSRC_IMPL_GROUP2 & cap4));
      wq.push_back((i == 2) ? PSRC_RESP_SLVERR : PSRC_RESP_OKAY);
      if (i < 2) shadow[i] = (shadow[i] & ~m) | (d & m);
      lq.push_back(exp_lines());
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= s;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge core_clk_in);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) req.bready <= 1'b0;
      end while (!rsp.bvalid);
   endtask

   // one read; notes the expected word and response
   task automatic rd(input logic [11:0] a);
      @(posedge core_clk_in);
      rq.push_back((a == PSRC_OFS_GROUP1) ? {PSRC_RESP_OKAY, shadow[0]} :
                   (a == PSRC_OFS_GROUP2) ? {PSRC_RESP_OKAY, shadow[1]} :
                   {PSRC_RESP_SLVERR, 32'h00000000});
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge core_clk_in);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) req.rready <= 1'b0;
      end while (!rsp.rvalid);
   endtask

   // monitor: each answer against the oldest note; lines one edge after the write
   // answer, units one edge later still
   always @(posedge core_clk_in) begin
      if (l_done) chk_units(l_exp, fresh);
      if (b_done) begin
         l_exp = lq.pop_front();
         chk_lines(l_exp, lines);
      end
      l_done <= b_done;
      b_done <= rsp.bvalid && req.bready;
      if (rsp.bvalid && req.bready) chk_resp(wq.pop_front(), rsp.bresp);
      if (rsp.rvalid && req.rready) chk_read(rq.pop_front(), {rsp.rresp, rsp.rdata});
   end

   // watchdog against a hung handshake
   initial begin
      #300000;
      miscompares++;
      test_done();
   end

   // main sequence
   initial begin
      rst_b_in = 1'b0;
      req = '0;
      cap2 = 32'h00000000;
      cap4 = 32'h00000000;
      shadow[0] = 32'h00000000;
      shadow[1] = 32'h00000000;
      repeat (6) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      rd(PSRC_OFS_GROUP1);
      rd(PSRC_OFS_GROUP2);
      rd(12'h040);
      wr(PSRC_OFS_GROUP1, 32'hFFFFFFFF, 4'hF);
      wr(PSRC_OFS_GROUP2, 32'hFFFFFFFF, 4'hF);
      cap2 <= 32'hFFFFFFFF;
      cap4 <= 32'hFFFFFFFF;
      wr(PSRC_OFS_GROUP1, 32'hFFFFFFFF, 4'hF);
      wr(PSRC_OFS_GROUP2, 32'hFFFFFFFF, 4'hF);
      wr(12'h04C, 32'h00000000, 4'hF);
      repeat (30) @(posedge core_clk_in);
      rd(PSRC_OFS_GROUP1);
      rd(PSRC_OFS_GROUP2);
      // random data, byte lanes and capability masks
      for (int k = 0; k < 24; k++) begin
         cap2 <= $random(seed);
         cap4 <= $random(seed);
         rnd = $random(seed);
         wr(k[0] ? PSRC_OFS_GROUP2 : PSRC_OFS_GROUP1, rnd, rnd[7:4] | rnd[3:0]);
         rd(PSRC_OFS_GROUP1);
         rd(PSRC_OFS_GROUP2);
      end
      cap2 <= 32'hFFFFFFFF;
      cap4 <= 32'hFFFFFFFF;
      wr(PSRC_OFS_GROUP1, 32'h00000000, 4'hF);
      wr(PSRC_OFS_GROUP2, 32'hFFFFFFFF, 4'hF);
      // reset in mid-run clears both registers, once the last write is checked
      repeat (3) @(posedge core_clk_in);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      shadow[0] = 32'h00000000;
      shadow[1] = 32'h00000000;
      repeat (2) @(posedge core_clk_in);
      #1;
      chk_lines(exp_lines(), lines);
      rd(PSRC_OFS_GROUP2);
      // let the monitor take the last answer before the verdict
      repeat (3) @(posedge core_clk_in);
      test_done();
   end
endmodule // tb_top
